// ==== sim/cor_vid_src.sv ====
`timescale 1ns/1ps
// ==========
// video source model
// clock only toggles inside a frame, as a real decoder gated by sync would
module cor_vid_src (
  output logic vid_clk,
  output logic vid_de,
  output logic vid_vs
);
  initial begin
    vid_clk = 1'b0;
    vid_de  = 1'b0;
    vid_vs  = 1'b0;
  end
  task automatic edge_out(input logic vs, input logic de);
    vid_vs = vs;
    vid_de = de;
    #16 vid_clk = 1'b1;
    #32 vid_clk = 1'b0;
    #16;
  endtask
  // source never waits on the capture side, so overflow is up to the device
  task automatic send_frame(input int n);
    edge_out(1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      edge_out(1'b0, 1'b1);
    end
    edge_out(1'b0, 1'b0);
  endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`include "cor_consts.svh"
module testbench;
  import cor_pkg::*;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } cor_row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        vid_clk, vid_de, vid_vs, mem_ack, overflow, ack_en, tile_exp;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  cor_mem_t    mem;
  int          miscompares, checks_done, wseen, dseen;
  // ==========
  // register rows: write, then expected readback
  localparam cor_row_t rows [8] = '{
    '{`COR_OFF_RST, 32'h0000_0001, 32'h0000_0001},
    '{`COR_OFF_PB0, 32'h0000_0006, 32'h0000_0006},
    '{`COR_OFF_PA1, 32'ha5a5_0007, 32'ha5a5_0007},
    '{`COR_OFF_PB1, 32'h5a5a_0006, 32'h5a5a_0006},
    '{`COR_OFF_IN_SIZE, 32'h0004_0004, 32'h0004_0004},
    '{`COR_OFF_OUT_SIZE, 32'h0002_0004, 32'h0002_0004},
    '{`COR_OFF_BASE, 32'h0001_0000, 32'h0001_0000},
    '{16'h5600, 32'hffff_ffff, 32'h0000_0000}
  };
  cor_capture cor_capture_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .vid_clk(vid_clk),
    .vid_de(vid_de), .vid_vs(vid_vs), .mem(mem), .mem_ack(mem_ack), .overflow(overflow)
  );
  cor_vid_src cor_vid_src_inst (.vid_clk(vid_clk), .vid_de(vid_de), .vid_vs(vid_vs));
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========
  // bus master: hold each phase until hready is sampled high
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= {16'h0000, a};
    hwrite <= wr;
    hsel <= 1'b1;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    chk(what, exp, v);
  endtask
  // ==========
  // memory side: one-cycle ack, words checked until the first descriptor
  always @(posedge hclk) begin
    mem_ack <= ack_en && mem.req && !mem_ack;
    if (mem_ack && !mem.desc && dseen == 0) begin
      chk("word addr", 32'h0001_0000 + 32'(4 * wseen), mem.addr);
      chk("word tiled", 32'(tile_exp), 32'(mem.tiled));
      wseen++;
    end
    if (mem_ack && mem.desc) begin
      if (dseen == 0) begin
        chk("desc addr", 32'h0001_0000 + 32'(4 * wseen), mem.addr);
        chk("desc tiled", 32'(tile_exp), 32'(mem.tiled));
        chk("words before desc", 32'd8, 32'(wseen));
      end
      dseen++;
    end
  end
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    miscompares++;
    test_done();
  end
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, hresetn} = '0;
    {ack_en, tile_exp, wseen, dseen} = '0;
    hsize = 3'b010;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("overflow at reset", 32'h0, 32'(overflow));
    foreach (rows[i]) begin
      rd_chk("reset value", rows[i].addr, `COR_REG_RESET);
      wr(rows[i].addr, rows[i].wdata);
      rd_chk("readback", rows[i].addr, rows[i].rdata);
    end
    wr(`COR_OFF_STATUS, 32'h0000_0001);
    rd_chk("status w1c idle", `COR_OFF_STATUS, 32'h0000_0000);
    // memory stalled: buffer fills and the parser must overflow
    wr(`COR_OFF_DMA_CTL, 32'h0000_0000);
    wr(`COR_OFF_RST, 32'h0000_0000);
    wr(`COR_OFF_PB0, 32'h0000_0000);
    // frame bigger than the buffer, so the stall really fills it
    wr(`COR_OFF_IN_SIZE, 32'h0040_0040);
    wr(`COR_OFF_PA0, 32'h0000_0001);
    cor_vid_src_inst.send_frame(1030);
    repeat (20) @(posedge hclk);
    chk("overflow flag", 32'h1, 32'(overflow));
    rd_chk("status full", `COR_OFF_STATUS, {`COR_BUF_WORDS, 21'h00_0007});
    wr(`COR_OFF_PA0, 32'h0000_0000);
    wr(`COR_OFF_RST, 32'h0000_0001);
    ack_en = 1'b0;
    wr(`COR_OFF_PA0, 32'h0000_0006);
    // stands in for the abort list completing while reset is held
    repeat (4) @(posedge hclk);
    bus(1'b0, `COR_OFF_STATUS, 32'h0, x);
    chk("status in reset", 32'h0, x & 32'hffff_fffe);
    chk("mem req in reset", 32'h0, 32'(mem.req));
    wr(`COR_OFF_STATUS, 32'h0000_0001);
    @(posedge hclk);
    chk("overflow cleared", 32'h0, 32'(overflow));
    wr(`COR_OFF_RST, 32'h0000_0000);
    wr(`COR_OFF_PA0, 32'h0000_0000);
    wr(`COR_OFF_IN_SIZE, 32'h0004_0004);
    // short frame, single channel, scaler on, tiled: output padded to 8 words
    ack_en = 1'b1;
    tile_exp = 1'b1;
    wr(`COR_OFF_DMA_CTL, 32'h0000_0005);
    wr(`COR_OFF_PA0, 32'h0000_0001);
    cor_vid_src_inst.send_frame(3);
    cor_vid_src_inst.edge_out(1'b1, 1'b1);
    cor_vid_src_inst.edge_out(1'b0, 1'b0);
    repeat (300) @(posedge hclk);
    chk("descriptor written", 32'h1, 32'(dseen > 0));
    test_done();
  end
endmodule

// ==== verilog/cor_capture.sv ====
`timescale 1ns/1ps
`include "cor_consts.svh"
module cor_capture (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic [31:0]         hrdata,
  output logic                hresp,
  input  wire logic           vid_clk,
  input  wire logic           vid_de,
  input  wire logic           vid_vs,
  output cor_pkg::cor_mem_t   mem,
  input  wire logic           mem_ack,
  output logic                overflow
);
  import cor_pkg::*;

  cor_state_t st;
  cor_state_t next_st;
  logic       edge_v;
  logic       pix;
  logic       fs;
  logic       dp_rst;
  logic       fifo_clr;
  logic       enable;
  logic       scl_on;
  logic       single;
  logic       full;
  logic       take;
  logic       pix_ok;
  logic       push;
  logic [31:0] in_total;
  logic [31:0] out_total;
  logic [31:0] desc_addr;

  // ==========================================================
  // register decode
  function automatic logic [3:0] reg_sel(input logic [15:0] a);
    case (a)
      `COR_OFF_RST:      reg_sel = `COR_IDX_RST;
      `COR_OFF_PA0:      reg_sel = `COR_IDX_PA0;
      `COR_OFF_PB0:      reg_sel = `COR_IDX_PB0;
      `COR_OFF_PA1:      reg_sel = `COR_IDX_PA1;
      `COR_OFF_PB1:      reg_sel = `COR_IDX_PB1;
      `COR_OFF_IN_SIZE:  reg_sel = `COR_IDX_IN_SIZE;
      `COR_OFF_OUT_SIZE: reg_sel = `COR_IDX_OUT_SIZE;
      `COR_OFF_DMA_CTL:  reg_sel = `COR_IDX_DMA_CTL;
      `COR_OFF_BASE:     reg_sel = `COR_IDX_BASE;
      `COR_OFF_STATUS:   reg_sel = `COR_IDX_STATUS;
      default:           reg_sel = `COR_IDX_NONE;
    endcase
  endfunction

  function automatic logic [31:0] rd_mux(input cor_state_t s, input logic [3:0] i);
    if (i <= `COR_IDX_BASE)
      rd_mux = s.regs[i];
    else if (i == `COR_IDX_STATUS)
      rd_mux = {s.level, 17'h0_0000, s.sc, s.ps, s.ovf_sticky};
    else
      rd_mux = 32'h0000_0000;
  endfunction

  // ==========================================================
  // derived controls
  always_comb begin
    dp_rst   = st.regs[`COR_IDX_RST][`COR_RST_DP_BIT];
    fifo_clr = st.regs[`COR_IDX_PA0][`COR_PORT_WCLR_BIT]
             | st.regs[`COR_IDX_PA0][`COR_PORT_RCLR_BIT]
             | st.regs[`COR_IDX_PB0][`COR_PORT_WCLR_BIT]
             | st.regs[`COR_IDX_PB0][`COR_PORT_RCLR_BIT];
    // both ports of the instance feed the one parser
    enable   = (st.regs[`COR_IDX_PA0][`COR_PORT_EN_BIT] | st.regs[`COR_IDX_PB0][`COR_PORT_EN_BIT])
             & ~dp_rst & ~fifo_clr;
    scl_on   = st.regs[`COR_IDX_DMA_CTL][`COR_DMA_SCL_BIT];
    single   = ~st.regs[`COR_IDX_DMA_CTL][`COR_DMA_MULTI_BIT];
    in_total  = {16'h0000, st.regs[`COR_IDX_IN_SIZE][15:0]}
              * {16'h0000, st.regs[`COR_IDX_IN_SIZE][31:16]};
    out_total = scl_on ? {16'h0000, st.regs[`COR_IDX_OUT_SIZE][15:0]}
              * {16'h0000, st.regs[`COR_IDX_OUT_SIZE][31:16]} : in_total;
    // descriptor goes right after the frame region, never inside it
    desc_addr = st.regs[`COR_IDX_BASE] + {out_total[29:0], 2'b00};
    // link clock is only sampled; rising edge found from the later stages
    edge_v   = st.clk_s[1] & ~st.clk_s[2];
    pix      = edge_v & st.de_s[1] & enable;
    fs       = edge_v & st.vs_s[1] & ~st.vs_q & enable;
    full     = (st.level == `COR_BUF_WORDS);
    take     = (~scl_on | (st.sc == COR_SC_PASS)) & ~full;
    pix_ok   = pix & (st.ps == COR_PS_RUN) & take;
    push     = (st.sc == COR_SC_FILL) ? ~full & (st.out_cnt < out_total)
             : pix_ok & (st.out_cnt < out_total);
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    // bus slave, zero wait, always okay
    next_st.wr_pend = 1'b0;
    next_st.hrdata  = 32'h0000_0000;
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        next_st.wr_pend = 1'b1;
        next_st.wr_idx  = reg_sel(haddr[15:0]);
      end else begin
        next_st.hrdata = rd_mux(st, reg_sel(haddr[15:0]));
      end
    end
    if (st.wr_pend) begin
      if (st.wr_idx <= `COR_IDX_BASE)
        next_st.regs[st.wr_idx] = hwdata;
      else if (st.wr_idx == `COR_IDX_STATUS && hwdata[`COR_STAT_OVF_BIT])
        next_st.ovf_sticky = 1'b0;
    end

    // synchronisers
    next_st.clk_s = {st.clk_s[1:0], vid_clk};
    next_st.de_s  = {st.de_s[0], vid_de};
    next_st.vs_s  = {st.vs_s[0], vid_vs};
    if (edge_v)
      next_st.vs_q = st.vs_s[1];
    if (fifo_clr)
      next_st.vs_q = 1'b0;

    // parser
    unique case (st.ps)
      COR_PS_IDLE: begin
        if (fs)
          next_st.ps = COR_PS_RUN;
      end
      COR_PS_RUN: begin
        if (pix && !take) begin
          next_st.ps         = COR_PS_OVF;
          next_st.ovf_sticky = 1'b1;
        end
      end
      COR_PS_OVF: begin
        // lines dropped until the next frame start
        if (fs)
          next_st.ps = COR_PS_RUN;
      end
      // code 2'b10 is never entered; fall back rather than stick
      default: next_st.ps = COR_PS_IDLE;
    endcase

    // scaler
    unique case (st.sc)
      COR_SC_PASS: begin
        if (pix_ok)
          next_st.in_cnt = st.in_cnt + 32'h0000_0001;
        if (fs) begin
          if (scl_on && single && st.in_cnt != 32'h0000_0000 && st.in_cnt < in_total
              && st.out_cnt < out_total) begin
            next_st.sc = COR_SC_FILL;
          end else begin
            next_st.in_cnt  = 32'h0000_0000;
            next_st.out_cnt = 32'h0000_0000;
          end
        end
      end
      COR_SC_FILL: begin
        // free-running fill, the source keeps going meanwhile
        if (st.out_cnt >= out_total) begin
          next_st.sc      = COR_SC_PASS;
          next_st.in_cnt  = 32'h0000_0000;
          next_st.out_cnt = 32'h0000_0000;
        end
      end
    endcase
    if (push) begin
      next_st.out_cnt = st.out_cnt + 32'h0000_0001;
      next_st.level   = st.level + 11'h001;
      if (st.out_cnt + 32'h0000_0001 == out_total)
        next_st.desc_pend = 1'b1;
    end

    // dma write-out
    if (st.mem.req && mem_ack) begin
      next_st.mem.req = 1'b0;
      if (st.mem.desc) begin
        next_st.desc_pend = 1'b0;
        next_st.wr_word   = 32'h0000_0000;
      end else begin
        next_st.level   = next_st.level - 11'h001;
        next_st.wr_word = st.wr_word + 32'h0000_0001;
      end
    end
    if (!next_st.mem.req) begin
      next_st.mem.tiled = st.regs[`COR_IDX_DMA_CTL][`COR_DMA_TILE_BIT];
      if (next_st.level != 11'h000) begin
        next_st.mem.req  = 1'b1;
        next_st.mem.desc = 1'b0;
        next_st.mem.addr = st.regs[`COR_IDX_BASE] + {next_st.wr_word[29:0], 2'b00};
      end else if (next_st.desc_pend) begin
        next_st.mem.req  = 1'b1;
        next_st.mem.desc = 1'b1;
        next_st.mem.addr = desc_addr;
      end
    end

    // instance reset clears parser, scaler and dma together
    if (dp_rst) begin
      next_st.ps        = COR_PS_IDLE;
      next_st.sc        = COR_SC_PASS;
      next_st.in_cnt    = 32'h0000_0000;
      next_st.out_cnt   = 32'h0000_0000;
      next_st.level     = 11'h000;
      next_st.wr_word   = 32'h0000_0000;
      next_st.desc_pend = 1'b0;
      next_st.mem.req   = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.hrdata;
  assign mem       = st.mem;
  assign overflow  = st.ovf_sticky;

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_fill;
    st.sc == COR_SC_FILL && !full && st.out_cnt < out_total && !dp_rst;
  endsequence
  sequence s_desc_out;
    st.mem.req && st.mem.desc;
  endsequence

  fill_entry_mode_a: assert property (
    $rose(st.sc == COR_SC_FILL) |-> $past(scl_on) && $past(single))
    else $error("fill entered outside single channel scaler mode");
  out_size_cap_a: assert property (push |-> st.out_cnt < out_total)
    else $error("scaler pushed past programmed output size");
  fill_no_req_a: assert property (st.sc == COR_SC_FILL && scl_on |-> !take)
    else $error("scaler requested data while filling");
  full_ovf_a: assert property (
    pix && st.ps == COR_PS_RUN && full && !dp_rst |=> st.ps == COR_PS_OVF && st.ovf_sticky)
    else $error("full buffer did not raise overflow");
  ovf_drop_a: assert property (st.ps == COR_PS_OVF |-> !pix_ok)
    else $error("pixel accepted during overflow");
  fill_rate_a: assert property (
    s_fill |=> st.out_cnt == $past(st.out_cnt) + 32'h0000_0001)
    else $error("fill did not run at full rate");
  dp_reset_a: assert property (
    dp_rst |=> st.level == 11'h000 && st.ps == COR_PS_IDLE && st.sc == COR_SC_PASS && !st.mem.req)
    else $error("datapath reset left state behind");
  tiled_desc_a: assert property (
    $rose(st.mem.req) |-> st.mem.tiled == $past(st.regs[`COR_IDX_DMA_CTL][`COR_DMA_TILE_BIT]))
    else $error("descriptor placement differs from frame placement");
  desc_after_a: assert property (
    s_desc_out |-> st.level == 11'h000 && st.mem.addr >= st.regs[`COR_IDX_BASE])
    else $error("descriptor written over frame data");
  sticky_hold_a: assert property (
    st.ovf_sticky && !(st.wr_pend && st.wr_idx == `COR_IDX_STATUS) |=> st.ovf_sticky)
    else $error("overflow flag dropped without a clear");

  // memory request waiting, and memory word taken
  sequence s_req_wait;
    st.mem.req && !mem_ack && !dp_rst;
  endsequence
  sequence s_word_ack;
    st.mem.req && !st.mem.desc && mem_ack && !dp_rst;
  endsequence
  fill_mode_gate_a: assert property (
    st.sc == COR_SC_PASS && !(scl_on && single) |=> st.sc == COR_SC_PASS)
    else $error("fill started outside single channel scaler mode");
  desc_last_a: assert property (
    $rose(st.desc_pend) |-> st.out_cnt == out_total)
    else $error("descriptor queued before full output frame");
  level_cap_a: assert property (
    st.level <= `COR_BUF_WORDS)
    else $error("buffer occupancy beyond its size");
  level_drain_a: assert property (
    s_word_ack ##0 !push |=> st.level == $past(st.level) - 11'h001)
    else $error("accepted word did not leave the buffer");
  ovf_hold_a: assert property (
    st.ps == COR_PS_OVF && !fs && !dp_rst |=> st.ps == COR_PS_OVF)
    else $error("overflow left before next frame start");
  ovf_no_push_a: assert property (
    st.ps == COR_PS_OVF && st.sc == COR_SC_PASS |-> !push)
    else $error("pixel pushed while parser in overflow");
  ovf_cause_a: assert property (
    $rose(st.ps == COR_PS_OVF) |-> $past(full) || $past(st.sc == COR_SC_FILL))
    else $error("overflow without full buffer or fill");
  fill_exit_a: assert property (
    st.sc == COR_SC_FILL && st.out_cnt >= out_total |=> st.sc == COR_SC_PASS
    && st.out_cnt == 32'h0000_0000)
    else $error("fill did not end at output size");
  dp_reset_counts_a: assert property (
    dp_rst |=> st.in_cnt == 32'h0000_0000 && st.out_cnt == 32'h0000_0000 && !st.desc_pend)
    else $error("datapath reset left counters behind");
  port_stop_a: assert property (
    dp_rst || fifo_clr |-> !pix && !fs)
    else $error("port took data while held in reset");
  req_hold_a: assert property (
    s_req_wait |=> st.mem.req && $stable(st.mem.addr) && $stable(st.mem.tiled)
    && $stable(st.mem.desc))
    else $error("memory request changed before accept");
  desc_once_a: assert property (
    s_desc_out && mem_ack |=> !st.desc_pend)
    else $error("descriptor still pending after accept");
  word_order_a: assert property (
    s_word_ack |=> st.wr_word == $past(st.wr_word) + 32'h0000_0001)
    else $error("frame word address did not advance");
  ovf_set_flag_a: assert property (
    $rose(st.ps == COR_PS_OVF) |-> st.ovf_sticky)
    else $error("overflow entered without setting the flag");
  ovf_clear_a: assert property (
    st.wr_pend && st.wr_idx == `COR_IDX_STATUS && hwdata[`COR_STAT_OVF_BIT]
    && !(pix && st.ps == COR_PS_RUN && !take) |=> !st.ovf_sticky)
    else $error("overflow flag not cleared by software");
endmodule

// ==== verilog/cor_consts.svh ====
`ifndef COR_CONSTS_SVH
`define COR_CONSTS_SVH
// ==========================================================
// register byte offsets
`define COR_OFF_RST       16'h0104
`define COR_OFF_PA0       16'h5504
`define COR_OFF_PB0       16'h550c
`define COR_OFF_PA1       16'h5a04
`define COR_OFF_PB1       16'h5a0c
`define COR_OFF_IN_SIZE   16'h5510
`define COR_OFF_OUT_SIZE  16'h5514
`define COR_OFF_DMA_CTL   16'h5518
`define COR_OFF_BASE      16'h551c
`define COR_OFF_STATUS    16'h5520
// ==========================================================
// register indices inside the block
`define COR_IDX_RST       4'h0
`define COR_IDX_PA0       4'h1
`define COR_IDX_PB0       4'h2
`define COR_IDX_PA1       4'h3
`define COR_IDX_PB1       4'h4
`define COR_IDX_IN_SIZE   4'h5
`define COR_IDX_OUT_SIZE  4'h6
`define COR_IDX_DMA_CTL   4'h7
`define COR_IDX_BASE      4'h8
`define COR_IDX_STATUS    4'h9
`define COR_IDX_NONE      4'hf
// ==========================================================
// field positions
`define COR_RST_DP_BIT    0
`define COR_PORT_EN_BIT   0
`define COR_PORT_WCLR_BIT 1
`define COR_PORT_RCLR_BIT 2
`define COR_DMA_SCL_BIT   0
`define COR_DMA_MULTI_BIT 1
`define COR_DMA_TILE_BIT  2
`define COR_STAT_OVF_BIT  0
// ==========================================================
// reset values and sizes
`define COR_REG_RESET     32'h0000_0000
`define COR_BUF_BYTES     4096
`define COR_BUF_WORDS     11'h400
`endif

// ==== verilog/cor_pkg.sv ====
package cor_pkg;
  typedef enum logic [1:0] {
    COR_PS_IDLE = 2'b00,
    COR_PS_RUN  = 2'b01,
    COR_PS_OVF  = 2'b11
  } cor_parse_t;
  typedef enum logic {
    COR_SC_PASS = 1'b0,
    COR_SC_FILL = 1'b1
  } cor_scale_t;
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic        desc;
    logic        tiled;
  } cor_mem_t;
  typedef struct packed {
    logic             wr_pend;
    logic [3:0]       wr_idx;
    logic [8:0][31:0] regs;
    logic             ovf_sticky;
    logic [2:0]       clk_s;
    logic [1:0]       de_s;
    logic [1:0]       vs_s;
    logic             vs_q;
    cor_parse_t       ps;
    cor_scale_t       sc;
    logic [31:0]      in_cnt;
    logic [31:0]      out_cnt;
    logic [10:0]      level;
    logic [31:0]      wr_word;
    logic             desc_pend;
    cor_mem_t         mem;
    logic [31:0]      hrdata;
  } cor_state_t;
endpackage
